// ---- hdl/ccfa_core.sv ----
// Purpose: card-side command interpreter and file addressing
// Assumes: decoded command fields and current file attributes arrive on clk
// Notes:   file data lives in an outside store reached by the acc* handshake
// What this block does
// - classify each exchange into one of four cases
// - replace 9000 by 91XX while proactive command waits, except on fetch
// - envelope answered 9300 while toolkit is busy
// - transparent access by byte offset from zero
// - linear records equal length, numbered from one
// - unset pointer: next gives first, previous last
// - linear next refused at last, previous at first
// - linear records reachable by number and search
// - failed record operation keeps previous pointer
// - linear file: 254 records, 255 bytes max
// - cyclic write replaces the oldest record
// - cyclic next after record n wraps to 1
// - cyclic previous before record 1 wraps to n
// - cyclic record 1 newest, record n oldest
// - cyclic write by previous only
// - cyclic file: 254 records, 254 bytes max
// - telecom directory 7F10 only under master directory
// - short identifier makes file current, clears pointer
`timescale 1ns/1ps
`include "ccfa_map.svh"
module ccfa_core
  import ccfa_pkg::*;
#(
  parameter logic [7:0] INS_SELECT   = 8'h01,
  parameter logic [7:0] INS_READ_BIN = 8'h02,
  parameter logic [7:0] INS_UPD_BIN  = 8'h03,
  parameter logic [7:0] INS_READ_REC = 8'h04,
  parameter logic [7:0] INS_UPD_REC  = 8'h05,
  parameter logic [7:0] INS_SEARCH   = 8'h06,
  parameter logic [7:0] INS_ENVELOPE = 8'h07
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clkEn,
  input  wire logic        cmdValid,
  input  wire logic [7:0]  cmdIns,
  input  wire ccfa_mode_t  cmdMode,
  input  wire logic [7:0]  cmdRecNum,
  input  wire logic [15:0] cmdOffset,
  input  wire logic [7:0]  cmdLen,
  input  wire logic        cmdHasData,
  input  wire logic        cmdSfiValid,
  input  wire logic [15:0] cmdFid,
  input  wire logic        dirIsMaster,
  input  wire ccfa_ftype_t fileType,
  input  wire logic [7:0]  fileRecLen,
  input  wire logic [7:0]  fileRecCount,
  input  wire logic [15:0] fileSize,
  input  wire logic [7:0]  fileHead,
  input  wire logic        proactivePending,
  input  wire logic [7:0]  proactiveLen,
  input  wire logic        toolkitBusy,
  input  wire logic        envWarn,
  input  wire logic [15:0] envWarnSw,
  input  wire logic [7:0]  envRspLen,
  input  wire logic        accDone,
  input  wire logic        accOk,
  input  wire logic [7:0]  accHitRec,
  output logic             cmdReady,
  output logic             accValid,
  output logic             accWrite,
  output logic             accSearch,
  output logic [15:0]      accAddr,
  output logic [7:0]       accLen,
  output logic [7:0]       accRec,
  output logic             rspValid,
  output logic [15:0]      rspSw,
  output logic [7:0]       rspLen,
  output ccfa_case_t       rspCase,
  output logic [7:0]       recPtr,
  output logic             recPtrSet,
  output logic [7:0]       cycHead,
  output logic [15:0]      selFileLen,
  output logic [7:0]       selRecLen,
  output logic [15:0]      selTotal
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  ccfa_state_t st;
  logic        effSet, isCyc, isRec, cycUpd, recBad, isFetch;
  logic        dNeedAcc, lRecOp, lCycUpd, lCmdData, lFetch;
  logic [15:0] dSw, dAddr;
  logic [7:0]  dRec, dSlot, dRspLen, newHead, lRspLen, lNewHead;
  logic [8:0]  sum9;

  function automatic logic [15:0] finSw(input logic [15:0] sw, input logic fetch,
                                        input logic pend, input logic [7:0] plen);
    // only a clean completion may carry the pending notice
    finSw = (sw == `CCFA_SW_OK && pend && !fetch) ? {`CCFA_SW1_PEND, plen} : sw;
  endfunction : finSw

  always_comb begin
    effSet   = recPtrSet && !cmdSfiValid;
    isCyc    = fileType == FT_CYCLIC;
    isFetch  = cmdIns == `CCFA_INS_FETCH;
    isRec    = cmdIns == INS_READ_REC || cmdIns == INS_UPD_REC;
    cycUpd   = isCyc && cmdIns == INS_UPD_REC;
    // 255-byte linear cap is the width of fileRecLen itself
    recBad   = fileRecCount == 8'h00 || fileRecCount > `CCFA_MAX_RECS ||
               fileRecLen == 8'h00 || (isCyc && fileRecLen > `CCFA_MAX_CYC_LEN);
    dSw      = `CCFA_SW_OK;
    dRec     = `CCFA_FIRST_REC;
    dNeedAcc = 1'b0;
    dRspLen  = 8'h00;
    dAddr    = `CCFA_OFS_ZERO;
    unique case (cmdMode)
      MODE_ABS: begin
        dRec = cmdRecNum;
        if (cmdRecNum == 8'h00 || cmdRecNum > fileRecCount) dSw = `CCFA_SW_NOREC;
      end
      MODE_NEXT: begin
        if (!effSet) dRec = `CCFA_FIRST_REC;
        else if (recPtr != fileRecCount) dRec = recPtr + 8'h01;
        else if (isCyc) dRec = `CCFA_FIRST_REC;
        else dSw = `CCFA_SW_NOREC;
      end
      MODE_PREV: begin
        if (!effSet) dRec = fileRecCount;
        else if (recPtr != `CCFA_FIRST_REC) dRec = recPtr - 8'h01;
        else if (isCyc) dRec = fileRecCount;
        else dSw = `CCFA_SW_NOREC;
      end
      MODE_CUR: begin
        dRec = recPtr;
        if (!effSet) dSw = `CCFA_SW_NOREC;
      end
    endcase
    // a cyclic write always lands on the slot before the newest one
    newHead = (cycHead == 8'h00) ? fileRecCount - 8'h01 : cycHead - 8'h01;
    if (cycUpd) begin
      dRec = `CCFA_FIRST_REC;
      dSw  = (cmdMode == MODE_PREV) ? `CCFA_SW_OK : `CCFA_SW_NOTALW;
    end
    sum9 = {1'b0, cycHead} + {1'b0, dRec} - 9'h001;
    if (!isCyc) dSlot = dRec - 8'h01;
    else if (cycUpd) dSlot = newHead;
    else if (sum9 >= {1'b0, fileRecCount}) dSlot = 8'(sum9 - {1'b0, fileRecCount});
    else dSlot = sum9[7:0];
    // pointer-mode errors only concern record commands
    if (!isRec) dSw = `CCFA_SW_OK;
    if (isFetch) begin
      if (proactivePending) dRspLen = proactiveLen;
      else dSw = `CCFA_SW_NOTALW;
    end else if (cmdIns == `CCFA_INS_TRSP) begin
      dRspLen = 8'h00;
    end else if (cmdIns == INS_ENVELOPE) begin
      if (toolkitBusy) dSw = `CCFA_SW_BUSY;
      else begin
        dSw     = envWarn ? envWarnSw : `CCFA_SW_OK;
        dRspLen = envRspLen;
      end
    end else if (cmdIns == INS_SELECT) begin
      if (cmdFid == `CCFA_FID_TELECOM && !dirIsMaster) dSw = `CCFA_SW_NOFILE;
      else dRspLen = cmdLen;
    end else if (cmdIns == INS_READ_BIN || cmdIns == INS_UPD_BIN) begin
      dAddr = cmdOffset;
      if (fileType != FT_TRANSP) dSw = `CCFA_SW_NOTALW;
      else if ({1'b0, cmdOffset} + {9'h000, cmdLen} > {1'b0, fileSize}) dSw = `CCFA_SW_BADP;
      else begin
        dNeedAcc = 1'b1;
        if (cmdIns == INS_READ_BIN) dRspLen = cmdLen;
      end
    end else if (isRec || cmdIns == INS_SEARCH) begin
      dAddr = dSlot * fileRecLen;
      if ((fileType != FT_LINEAR && !isCyc) || recBad) dSw = `CCFA_SW_NOTALW;
      else if (cmdIns == INS_SEARCH) begin
        dSw      = `CCFA_SW_OK;
        dNeedAcc = 1'b1;
      end else begin
        dNeedAcc = dSw == `CCFA_SW_OK;
        if (cmdIns == INS_READ_REC) dRspLen = fileRecLen;
      end
    end else begin
      dSw = `CCFA_SW_BADINS;
    end
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  assign cmdReady = st == ST_IDLE;
  assign accValid = st == ST_ACCESS;
  assign rspValid = st == ST_RESP;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= ST_IDLE;
    end else if (clkEn) begin
      unique case (st)
        ST_IDLE:   if (cmdValid) st <= (dNeedAcc && dSw == `CCFA_SW_OK) ? ST_ACCESS : ST_RESP;
        ST_ACCESS: if (accDone) st <= ST_RESP;
        ST_RESP:   st <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      accWrite  <= 1'b0;
      accSearch <= 1'b0;
      accAddr   <= 16'h0000;
      accLen    <= 8'h00;
      accRec    <= 8'h00;
      lRecOp    <= 1'b0;
      lCycUpd   <= 1'b0;
      lNewHead  <= 8'h00;
      lRspLen   <= 8'h00;
      lCmdData  <= 1'b0;
      lFetch    <= 1'b0;
    end else if (clkEn && st == ST_IDLE && cmdValid) begin
      accWrite  <= cmdIns == INS_UPD_BIN || cmdIns == INS_UPD_REC;
      accSearch <= cmdIns == INS_SEARCH;
      accAddr   <= dAddr;
      accLen    <= isRec ? fileRecLen : cmdLen;
      accRec    <= dRec;
      lRecOp    <= isRec || cmdIns == INS_SEARCH;
      lCycUpd   <= cycUpd;
      lNewHead  <= newHead;
      lRspLen   <= dRspLen;
      lCmdData  <= cmdHasData;
      lFetch    <= isFetch;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rspSw   <= `CCFA_SW_OK;
      rspLen  <= 8'h00;
      rspCase <= CASE_1;
    end else if (clkEn) begin
      if (st == ST_IDLE && cmdValid && !(dNeedAcc && dSw == `CCFA_SW_OK)) begin
        rspSw   <= finSw(dSw, isFetch, proactivePending, proactiveLen);
        rspLen  <= (dSw == `CCFA_SW_OK || dSw[15:9] == 7'h31) ? dRspLen : 8'h00;
        rspCase <= ccfa_case_t'({cmdHasData, dRspLen != 8'h00});
      end else if (st == ST_ACCESS && accDone) begin
        rspSw   <= finSw(accOk ? `CCFA_SW_OK : `CCFA_SW_ACCFAIL, lFetch,
                         proactivePending, proactiveLen);
        rspLen  <= accOk ? lRspLen : 8'h00;
        rspCase <= ccfa_case_t'({lCmdData, accOk && lRspLen != 8'h00});
      end
    end
  end

  // ---------------------------------------------------------------
  // record pointer and file info
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      recPtr    <= 8'h00;
      recPtrSet <= 1'b0;
      cycHead   <= 8'h00;
    end else if (clkEn) begin
      if (st == ST_IDLE && cmdValid && cmdIns == INS_SELECT && dSw == `CCFA_SW_OK) begin
        recPtrSet <= 1'b0;
        cycHead   <= fileHead;
      end else if (st == ST_IDLE && cmdValid && (isRec || cmdIns == INS_SEARCH) &&
                   cmdSfiValid) begin
        recPtrSet <= 1'b0;
      end else if (st == ST_ACCESS && accDone && accOk && lRecOp) begin
        recPtrSet <= 1'b1;
        recPtr    <= accSearch ? accHitRec : accRec;
        if (lCycUpd) cycHead <= lNewHead;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      selFileLen <= 16'h0000;
      selRecLen  <= 8'h00;
      selTotal   <= 16'h0000;
    end else if (clkEn && st == ST_IDLE && cmdValid && cmdIns == INS_SELECT) begin
      selFileLen <= fileSize;
      selRecLen  <= fileRecLen;
      selTotal   <= fileRecLen * fileRecCount;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic go;
  assign go = st == ST_IDLE && cmdValid;

  property p_ptrKeep;
    @(posedge clk iff clkEn) disable iff (!arst_n)
      (st == ST_ACCESS && accDone && !accOk) |=>
        (recPtr == $past(recPtr) && recPtrSet == $past(recPtrSet) && rspValid);
  endproperty
  a_ptrKeep: assert property (p_ptrKeep) else $error("pointer moved on failed access");

  property p_busy;
    @(posedge clk iff clkEn) disable iff (!arst_n)
      (go && cmdIns == INS_ENVELOPE && toolkitBusy) |=> (rspValid && rspSw == `CCFA_SW_BUSY);
  endproperty
  a_busy: assert property (p_busy) else $error("busy envelope not answered 9300");

  property p_fetch;
    @(posedge clk iff clkEn) disable iff (!arst_n)
      (go && isFetch && proactivePending) |=>
        (rspValid && rspSw == `CCFA_SW_OK && rspLen == $past(proactiveLen));
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch answer wrong");

  property p_pend;
    @(posedge clk iff clkEn) disable iff (!arst_n)
      (go && cmdIns == `CCFA_INS_TRSP && proactivePending) |=>
        (rspSw == {`CCFA_SW1_PEND, $past(proactiveLen)});
  endproperty
  a_pend: assert property (p_pend) else $error("pending notice missing");

  property p_wrapNext;
    @(posedge clk iff clkEn) disable iff (!arst_n)
      (go && cmdIns == INS_READ_REC && isCyc && !recBad && cmdMode == MODE_NEXT &&
       effSet && recPtr == fileRecCount) |=> (accValid && accRec == `CCFA_FIRST_REC);
  endproperty
  a_wrapNext: assert property (p_wrapNext) else $error("cyclic next did not wrap");

  property p_wrapPrev;
    @(posedge clk iff clkEn) disable iff (!arst_n)
      (go && cmdIns == INS_READ_REC && isCyc && !recBad && cmdMode == MODE_PREV &&
       effSet && recPtr == `CCFA_FIRST_REC) |=> (accValid && accRec == $past(fileRecCount));
  endproperty
  a_wrapPrev: assert property (p_wrapPrev) else $error("cyclic previous did not wrap");

  property p_linEnd;
    @(posedge clk iff clkEn) disable iff (!arst_n)
      (go && isRec && fileType == FT_LINEAR && !recBad && cmdMode == MODE_NEXT &&
       effSet && recPtr == fileRecCount) |=> (rspValid && rspSw[15:8] == 8'h6a);
  endproperty
  a_linEnd: assert property (p_linEnd) else $error("linear next past end accepted");

  property p_cycPrev;
    @(posedge clk iff clkEn) disable iff (!arst_n)
      (go && cycUpd && !recBad && cmdMode != MODE_PREV) |=> (rspValid && !accValid);
  endproperty
  a_cycPrev: assert property (p_cycPrev) else $error("cyclic write not by previous");

  property p_select;
    @(posedge clk iff clkEn) disable iff (!arst_n)
      (go && cmdIns == INS_SELECT && (cmdFid != `CCFA_FID_TELECOM || dirIsMaster)) |=>
        (!recPtrSet && cycHead == $past(fileHead));
  endproperty
  a_select: assert property (p_select) else $error("select left pointer set");

  property p_limit;
    @(posedge clk iff clkEn) disable iff (!arst_n)
      (go && isRec && fileRecCount > `CCFA_MAX_RECS) |=> (rspValid && rspSw == `CCFA_SW_NOTALW);
  endproperty
  a_limit: assert property (p_limit) else $error("oversized file accepted");
endmodule : ccfa_core

// ---- inc/ccfa_map.svh ----
// Purpose: status words, codes and limits of the card command block
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef CCFA_MAP_SVH
`define CCFA_MAP_SVH
`define CCFA_SW_OK       16'h9000
`define CCFA_SW1_PEND    8'h91
`define CCFA_SW_BUSY     16'h9300
`define CCFA_SW_NOREC    16'h6a83
`define CCFA_SW_BADP     16'h6b00
`define CCFA_SW_NOFILE   16'h6a82
`define CCFA_SW_NOTALW   16'h6985
`define CCFA_SW_BADINS   16'h6d00
`define CCFA_SW_ACCFAIL  16'h6f00
`define CCFA_INS_FETCH   8'h12
`define CCFA_INS_TRSP    8'h14
`define CCFA_MAX_RECS    8'hfe
`define CCFA_MAX_CYC_LEN 8'hfe
`define CCFA_FID_TELECOM 16'h7f10
`define CCFA_FIRST_REC   8'h01
`define CCFA_OFS_ZERO    16'h0000
`endif

// ---- inc/ccfa_pkg.sv ----
// Purpose: types of the card command block
// Assumes: nothing
// Notes:   mode and file type codes are set by the file store
package ccfa_pkg;
  typedef enum logic [1:0] {MODE_ABS, MODE_NEXT, MODE_PREV, MODE_CUR} ccfa_mode_t;
  typedef enum logic [1:0] {FT_NONE, FT_TRANSP, FT_LINEAR, FT_CYCLIC} ccfa_ftype_t;
  typedef enum logic [1:0] {CASE_1, CASE_2, CASE_3, CASE_4} ccfa_case_t;
  typedef enum {ST_IDLE, ST_ACCESS, ST_RESP} ccfa_state_t;
endpackage : ccfa_pkg

// ---- tb/ccfa_store_model.sv ----
// Purpose: file store partner that answers the access handshake of the command block
// Assumes: one access at a time, accValid held until accDone is taken
// Notes:   wait length, ok flag and search hit are set by the bench
`timescale 1ns/1ps
module ccfa_store_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        accValid,
  input  wire logic [15:0] accAddr,
  input  wire logic [3:0]  waitCycles,
  input  wire logic        okIn,
  input  wire logic [7:0]  hitIn,
  output logic             accDone,
  output logic             accOk,
  output logic [7:0]       accHitRec,
  output logic [15:0]      lastAddr
);
  logic [3:0] waitCount;
  // ------------------------------------------------------------
  // answer
  // ------------------------------------------------------------
  // ok and hit toggle outside the done cycle so stale values never pass
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      accDone   <= 1'b0;
      accOk     <= 1'b0;
      accHitRec <= 8'h00;
      lastAddr  <= 16'h0000;
      waitCount <= 4'h0;
    end else begin
      accDone   <= 1'b0;
      accOk     <= ~accOk;
      accHitRec <= ~accHitRec;
      if (accValid && !accDone) begin
        if (waitCount == waitCycles) begin
          accDone   <= 1'b1;
          accOk     <= okIn;
          accHitRec <= hitIn;
          lastAddr  <= accAddr;
          waitCount <= 4'h0;
        end else begin
          waitCount <= waitCount + 4'h1;
        end
      end
    end
  end
endmodule : ccfa_store_model

// ---- tb/test_card_command_file_access.sv ----
// Purpose: self-checking bench of the card command block
// Assumes: store partner answers every access
// Notes:   table of plain commands first, record walks after
`timescale 1ns/1ps
`include "ccfa_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module test_card_command_file_access
  import ccfa_pkg::*;
;
  localparam logic [7:0] SEL = 8'h01, RBIN = 8'h02, RREC = 8'h04, UREC = 8'h05;
  localparam logic [7:0] SRCH = 8'h06, ENV = 8'h07;
  logic        clk, arst_n, clkEn, cmdValid, cmdHasData, cmdSfiValid, dirIsMaster;
  logic        proactivePending, toolkitBusy, envWarn, accDone, accOk, okIn;
  logic        cmdReady, accValid, accWrite, accSearch, rspValid, recPtrSet;
  logic [7:0]  cmdIns, cmdRecNum, cmdLen, fileRecLen, fileRecCount, fileHead, proactiveLen;
  logic [7:0]  envRspLen, accHitRec, hitIn, accLen, accRec, rspLen, recPtr, cycHead, selRecLen;
  logic [15:0] cmdOffset, cmdFid, fileSize, envWarnSw, accAddr, rspSw, selFileLen, selTotal;
  logic [15:0] lastAddr;
  logic [3:0]  waitCycles;
  ccfa_mode_t  cmdMode;
  ccfa_ftype_t fileType;
  ccfa_case_t  rspCase;
  int          err_count, n_checks;
  typedef struct packed {logic [7:0] ins; logic hd, pend, busy, warn, mst; logic [15:0] fid;
    ccfa_ftype_t ft; logic [7:0] rl, rc; logic [15:0] sw; logic full; logic [7:0] len;
    ccfa_case_t cs;} ccfa_row_t;
  ccfa_row_t rows [12] = '{
    '{8'h12,'0,'1,'0,'0,'1,16'h0,FT_NONE,8'h0,8'h0,16'h9000,'1,8'h1c,CASE_2},
    '{8'h12,'0,'0,'0,'0,'1,16'h0,FT_NONE,8'h0,8'h0,16'h6985,'1,8'h00,CASE_1},
    '{8'h14,'1,'0,'0,'0,'1,16'h0,FT_NONE,8'h0,8'h0,16'h9000,'1,8'h00,CASE_3},
    '{8'h14,'1,'1,'0,'0,'1,16'h0,FT_NONE,8'h0,8'h0,16'h911c,'1,8'h00,CASE_3},
    '{ENV,'1,'0,'1,'0,'1,16'h0,FT_NONE,8'h0,8'h0,16'h9300,'1,8'h00,CASE_3},
    '{ENV,'1,'0,'0,'1,'1,16'h0,FT_NONE,8'h0,8'h0,16'h6283,'1,8'h05,CASE_4},
    '{ENV,'1,'0,'0,'0,'1,16'h0,FT_NONE,8'h0,8'h0,16'h9000,'1,8'h05,CASE_4},
    '{8'h7e,'0,'0,'0,'0,'1,16'h0,FT_NONE,8'h0,8'h0,16'h6d00,'1,8'h00,CASE_1},
    '{SEL,'0,'0,'0,'0,'0,16'h7f10,FT_NONE,8'h0,8'h0,16'h6a82,'0,8'h00,CASE_1},
    '{RREC,'0,'0,'0,'0,'1,16'h6f3a,FT_LINEAR,8'hff,8'hfe,16'h9000,'0,8'h0,CASE_1},
    '{RREC,'0,'0,'0,'0,'1,16'h6f3a,FT_LINEAR,8'h10,8'hff,16'h6985,'0,8'h0,CASE_1},
    '{RREC,'0,'0,'0,'0,'1,16'h6f3a,FT_CYCLIC,8'hff,8'h04,16'h6985,'0,8'h0,CASE_1}};

  ccfa_core #(.INS_SELECT(SEL), .INS_READ_BIN(RBIN), .INS_READ_REC(RREC),
    .INS_UPD_REC(UREC), .INS_SEARCH(SRCH), .INS_ENVELOPE(ENV)) uut (
    .clk(clk), .arst_n(arst_n), .clkEn(clkEn), .cmdValid(cmdValid), .cmdIns(cmdIns),
    .cmdMode(cmdMode), .cmdRecNum(cmdRecNum), .cmdOffset(cmdOffset), .cmdLen(cmdLen),
    .cmdHasData(cmdHasData), .cmdSfiValid(cmdSfiValid), .cmdFid(cmdFid),
    .dirIsMaster(dirIsMaster), .fileType(fileType), .fileRecLen(fileRecLen),
    .fileRecCount(fileRecCount), .fileSize(fileSize), .fileHead(fileHead),
    .proactivePending(proactivePending), .proactiveLen(proactiveLen),
    .toolkitBusy(toolkitBusy), .envWarn(envWarn), .envWarnSw(envWarnSw),
    .envRspLen(envRspLen), .accDone(accDone), .accOk(accOk), .accHitRec(accHitRec),
    .cmdReady(cmdReady), .accValid(accValid), .accWrite(accWrite), .accSearch(accSearch),
    .accAddr(accAddr), .accLen(accLen), .accRec(accRec), .rspValid(rspValid),
    .rspSw(rspSw), .rspLen(rspLen), .rspCase(rspCase), .recPtr(recPtr),
    .recPtrSet(recPtrSet), .cycHead(cycHead), .selFileLen(selFileLen),
    .selRecLen(selRecLen), .selTotal(selTotal));
  ccfa_store_model store (.clk(clk), .arst_n(arst_n), .accValid(accValid), .accAddr(accAddr),
    .waitCycles(waitCycles), .okIn(okIn), .hitIn(hitIn), .accDone(accDone), .accOk(accOk),
    .accHitRec(accHitRec), .lastAddr(lastAddr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task report_and_stop();
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic cmd(input logic [7:0] ins, input ccfa_mode_t m, input logic [7:0] num,
                     input logic hd, input logic short_file_identifier);
    int k;
    @(posedge clk);
    cmdValid    <= 1'b1;
    cmdIns      <= ins;
    cmdMode     <= m;
    cmdRecNum   <= num;
    cmdHasData  <= hd;
    cmdSfiValid <= short_file_identifier;
    @(posedge clk);
    cmdValid <= 1'b0;
    // rspValid is a one-cycle pulse, so look once per cycle after the edge
    for (k = 0; k < 60; k++) begin
      #1;
      if (rspValid === 1'b1) break;
      @(posedge clk);
    end
    if (k == 60) begin
      err_count++;
      report_and_stop();
    end
  endtask : cmd
  task automatic rc(input logic [7:0] ins, input ccfa_mode_t m, input logic [7:0] num,
                    input logic [15:0] sw, input logic [7:0] ptr);
    cmd(ins, m, num, ins == UREC, 1'b0);
    `CHK(rspSw, sw)
    `CHK(recPtr, ptr)
  endtask : rc
  task automatic knob(input logic [3:0] w, input logic ok, input logic [7:0] hit,
                      input logic pend);
    @(posedge clk);
    waitCycles       <= w;
    okIn             <= ok;
    hitIn            <= hit;
    proactivePending <= pend;
  endtask : knob
  task automatic sel(input ccfa_ftype_t ft, input logic [7:0] rl, input logic [7:0] n,
                     input logic [7:0] hd);
    @(posedge clk);
    fileType     <= ft;
    fileRecLen   <= rl;
    fileRecCount <= n;
    fileHead     <= hd;
    cmdLen       <= rl;
    cmd(SEL, MODE_ABS, 8'h00, 1'b0, 1'b0);
    `CHK(rspSw, `CCFA_SW_OK)
    `CHK(recPtrSet, 1'b0)
  endtask : sel
  task automatic bin(input logic [15:0] ofs, input logic [7:0] len, input logic [15:0] sw);
    @(posedge clk);
    cmdOffset <= ofs;
    cmdLen    <= len;
    cmd(RBIN, MODE_ABS, 8'h00, 1'b0, 1'b0);
    `CHK(rspSw, sw)
  endtask : bin
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    {arst_n, cmdValid, cmdHasData, cmdSfiValid, proactivePending, toolkitBusy, envWarn} = '0;
    {clkEn, dirIsMaster, okIn} = '1;
    {cmdIns, cmdRecNum, cmdLen, fileRecLen, fileRecCount, fileHead, hitIn} = '0;
    {cmdOffset, cmdFid} = '0;
    cmdMode    = MODE_ABS;
    fileType   = FT_NONE;
    waitCycles = 4'h0;
    proactiveLen = 8'h1c;
    envRspLen    = 8'h05;
    envWarnSw    = 16'h6283;
    fileSize     = 16'h0040;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    `CHK(rspSw, `CCFA_SW_OK)
    `CHK(cmdReady, 1'b1)
    foreach (rows[i]) begin
      @(posedge clk);
      {proactivePending, toolkitBusy, envWarn} <= {rows[i].pend, rows[i].busy, rows[i].warn};
      {dirIsMaster, cmdFid} <= {rows[i].mst, rows[i].fid};
      fileType <= rows[i].ft;
      {fileRecLen, fileRecCount} <= {rows[i].rl, rows[i].rc};
      cmd(rows[i].ins, MODE_ABS, 8'h01, rows[i].hd, 1'b0);
      `CHK(rspSw, rows[i].sw)
      if (rows[i].full) begin
        `CHK(rspLen, rows[i].len)
        `CHK(rspCase, rows[i].cs)
      end
    end
    // linear walk, failures must leave the pointer alone
    sel(FT_LINEAR, 8'h10, 8'h03, 8'h00);
    `CHK(selTotal, 16'h0030)
    `CHK(selRecLen, 8'h10)
    rc(RREC, MODE_NEXT, 8'h00, `CCFA_SW_OK, 8'h01);
    `CHK(lastAddr, 16'h0000)
    rc(RREC, MODE_NEXT, 8'h00, `CCFA_SW_OK, 8'h02);
    rc(RREC, MODE_NEXT, 8'h00, `CCFA_SW_OK, 8'h03);
    rc(RREC, MODE_NEXT, 8'h00, `CCFA_SW_NOREC, 8'h03);
    rc(RREC, MODE_PREV, 8'h00, `CCFA_SW_OK, 8'h02);
    rc(RREC, MODE_PREV, 8'h00, `CCFA_SW_OK, 8'h01);
    rc(RREC, MODE_PREV, 8'h00, `CCFA_SW_NOREC, 8'h01);
    knob(4'd6, 1'b0, 8'h00, 1'b0);
    rc(RREC, MODE_ABS, 8'h03, `CCFA_SW_ACCFAIL, 8'h01);
    knob(4'd6, 1'b1, 8'h03, 1'b0);
    rc(RREC, MODE_ABS, 8'h02, `CCFA_SW_OK, 8'h02);
    `CHK(lastAddr, 16'h0010)
    cmd(SRCH, MODE_ABS, 8'h00, 1'b1, 1'b0);
    `CHK(recPtr, 8'h03)
    `CHK(accSearch, 1'b1)
    sel(FT_LINEAR, 8'h10, 8'h03, 8'h00);
    rc(RREC, MODE_PREV, 8'h00, `CCFA_SW_OK, 8'h03);
    cmd(RREC, MODE_CUR, 8'h00, 1'b0, 1'b1);
    `CHK(rspSw, `CCFA_SW_NOREC)
    `CHK(recPtrSet, 1'b0)
    knob(4'd0, 1'b1, 8'h00, 1'b1);
    rc(RREC, MODE_ABS, 8'h01, 16'h911c, 8'h01);
    knob(4'd0, 1'b1, 8'h00, 1'b0);
    // cyclic: slot of record k is (head + k - 1) mod n
    sel(FT_CYCLIC, 8'h08, 8'h04, 8'h00);
    cmd(UREC, MODE_NEXT, 8'h00, 1'b1, 1'b0);
    `CHK(rspSw, `CCFA_SW_NOTALW)
    rc(UREC, MODE_PREV, 8'h00, `CCFA_SW_OK, 8'h01);
    `CHK(cycHead, 8'h03)
    `CHK(accWrite, 1'b1)
    `CHK(lastAddr, 16'h0018)
    rc(UREC, MODE_PREV, 8'h00, `CCFA_SW_OK, 8'h01);
    `CHK(lastAddr, 16'h0010)
    rc(RREC, MODE_ABS, 8'h04, `CCFA_SW_OK, 8'h04);
    `CHK(lastAddr, 16'h0008)
    rc(RREC, MODE_NEXT, 8'h00, `CCFA_SW_OK, 8'h01);
    `CHK(lastAddr, 16'h0010)
    rc(RREC, MODE_PREV, 8'h00, `CCFA_SW_OK, 8'h04);
    // transparent, last byte exactly at the end of the file
    sel(FT_TRANSP, 8'h00, 8'h00, 8'h00);
    `CHK(selFileLen, 16'h0040)
    bin(16'h003a, 8'h06, `CCFA_SW_OK);
    `CHK(lastAddr, 16'h003a)
    `CHK(accLen, 8'h06)
    bin(16'h003b, 8'h06, `CCFA_SW_BADP);
    // enable low: an offered command must not be taken
    @(posedge clk);
    clkEn    <= 1'b0;
    cmdValid <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK(cmdReady, 1'b1)
    `CHK(rspValid, 1'b0)
    `CHK(rspSw, `CCFA_SW_BADP)
    @(posedge clk);
    clkEn    <= 1'b1;
    cmdValid <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(recPtrSet, 1'b0)
    `CHK(rspSw, `CCFA_SW_OK)
    `CHK(accValid, 1'b0)
    report_and_stop();
  end
endmodule : test_card_command_file_access
